/* ipd_pkg.sv */
// package for the idle and power-down mode controller
// assumes a 50 MHz system clock and an Avalon-MM slave with 32-bit data
// How it works
// - idle stops the cpu while peripherals, timers, serial port and interrupts run on.
// - idle itself changes no ram and no special function register.
// - idle ends on any enabled interrupt or on a hardware reset.
// - after a reset ends idle the cpu may run on for at most two machine cycles.
// - in that run-on window ram writes are blocked but port writes are not.
// - power-down stops the oscillator and the requesting instruction is the last one run.
// - ram and special function registers hold their values during power-down.
// - only a hardware reset ends power-down; interrupts do not.
// - the reset ending power-down restores register defaults and leaves ram alone.
// - strobes are high in idle and low in power-down; port 0 floats, port 2 shows address in external idle.
// - the oscillator input reaches internal clocking through a divide-by-two stage.
package ipd_pkg;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_STATUS        = 8'h88;
	localparam logic [7:0] POWER_CONTROL_RST  = 8'h00;
	localparam int         BIT_IDLE           = 0;
	localparam int         BIT_PDOWN          = 1;
	localparam logic [7:0] POWER_CONTROL_MASK = 8'h8f;
	localparam int         OSC_PER_MCYCLE     = 12;
	localparam int         RUNON_MCYCLES      = 2;
	localparam int         RUNON_CYCLES       = RUNON_MCYCLES * OSC_PER_MCYCLE / 2;
	localparam int         RESET_MCYCLES      = 2;
	localparam int         RESET_CYCLES       = RESET_MCYCLES * OSC_PER_MCYCLE / 2;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_PDOWN
	} ipd_state_t;

	typedef struct packed {
		logic       cpu_run;
		logic       periph_run;
		logic       osc_run;
		logic       ram_write_ok;
		logic       port0_float;
		logic       port2_addr;
	} ipd_ctrl_t;
endpackage : ipd_pkg

/* ipd_ctrl.sv */
// idle / power-down mode controller with Avalon-MM register access
// assumes CPU signals instr_done, enabled interrupt and external-fetch level
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module ipd_ctrl #(
	parameter int RUNON  = ipd_pkg::RUNON_CYCLES,
	parameter int RSTLEN = ipd_pkg::RESET_CYCLES
) (
	input  wire logic             CLK_SYS,
	input  wire logic             SYS_RST,
	input  wire logic             RST_PIN,
	input  wire logic             INSTR_DONE,
	input  wire logic             IRQ_ENABLED,
	input  wire logic             EXT_PROG_MEM,
	input  wire logic [7:0]       AVS_ADDRESS,
	input  wire logic             AVS_READ,
	input  wire logic             AVS_WRITE,
	input  wire logic [31:0]      AVS_WRITEDATA,
	input  wire logic [3:0]       AVS_BYTEENABLE,
	output logic      [31:0]      AVS_READDATA,
	output logic                  AVS_WAITREQUEST,
	output logic                  CLK_EN,
	output ipd_pkg::ipd_ctrl_t    CTRL,
	output logic                  ADDR_LATCH_STROBE,
	output logic                  PROGRAM_STORE_STROBE,
	output logic                  DEVICE_RESET,
	output logic [1:0]            MODE
);
	import ipd_pkg::*;

	ipd_state_t state;
	ipd_state_t next_state;
	logic [7:0] power_control;
	logic       div2;
	logic       pending_idle;
	logic       pending_pdown;
	logic [7:0] runon_cnt;
	logic [7:0] rst_cnt;
	logic       bus_done;
	logic       idle_wake;
	logic       rst_pin_q;

	// single-cycle wait then answer
	wire access      = AVS_READ | AVS_WRITE;
	wire hit_power_control    = AVS_ADDRESS == ADDR_POWER_CONTROL;
	wire hit_status  = AVS_ADDRESS == ADDR_STATUS;
	wire wr_power_control     = AVS_WRITE & bus_done & hit_power_control & AVS_BYTEENABLE[0];
	wire [7:0] wdata = AVS_WRITEDATA[7:0] & POWER_CONTROL_MASK;
	wire [31:0] rd_mux = hit_power_control   ? {24'h000000, power_control} :
	                     hit_status ? {30'h00000000, state} : 32'h00000000;

	// reset pin must stand for two machine cycles of running oscillator
	wire rst_long   = rst_cnt >= 8'(RSTLEN);
	wire runon_live = runon_cnt != 8'h00;
	assign idle_wake = IRQ_ENABLED;

	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (INSTR_DONE && pending_pdown)
					next_state = ST_PDOWN;
				else if (INSTR_DONE && pending_idle)
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (idle_wake)
					next_state = ST_RUN;
			end
			ST_PDOWN: next_state = ST_PDOWN;
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			div2 <= 1'b0;
		else if (state != ST_PDOWN)
			div2 <= ~div2;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rst_pin_q <= 1'b0;
			rst_cnt   <= 8'h00;
		end else begin
			rst_pin_q <= RST_PIN;
			if (!rst_pin_q)
				rst_cnt <= 8'h00;
			else if (!rst_long)
				rst_cnt <= rst_cnt + 8'h01;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST)
			runon_cnt <= 8'h00;
		// load once on the rising pin only, so the run-on stays bounded while reset is held
		else if (state == ST_IDLE && RST_PIN && !rst_pin_q)
			runon_cnt <= 8'(RUNON);
		else if (runon_live)
			runon_cnt <= runon_cnt - 8'h01;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST || rst_long) begin
			state         <= ST_RUN;
			power_control <= POWER_CONTROL_RST;
			pending_idle  <= 1'b0;
			pending_pdown <= 1'b0;
		end else begin
			state <= next_state;
			if (wr_power_control) begin
				power_control <= wdata;
				pending_idle  <= wdata[BIT_IDLE];
				pending_pdown <= wdata[BIT_PDOWN];
			end else if (state == ST_RUN && next_state != ST_RUN) begin
				pending_idle  <= 1'b0;
				pending_pdown <= 1'b0;
			end
			if (state == ST_IDLE && idle_wake)
				power_control[BIT_IDLE] <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			bus_done        <= 1'b0;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h00000000;
		end else begin
			bus_done        <= access & ~bus_done;
			AVS_WAITREQUEST <= ~(access & ~bus_done);
			if (AVS_READ && !bus_done)
				AVS_READDATA <= rd_mux;
		end
	end

	// idle: cpu off, peripherals on, nothing written by the mode itself
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			CTRL                 <= '{cpu_run: 1'b1, periph_run: 1'b1, osc_run: 1'b1,
			                          ram_write_ok: 1'b1, port0_float: 1'b0, port2_addr: 1'b0};
			ADDR_LATCH_STROBE    <= 1'b0;
			PROGRAM_STORE_STROBE <= 1'b0;
			CLK_EN               <= 1'b0;
			DEVICE_RESET         <= 1'b1;
			MODE                 <= 2'h0;
		end else begin
			CTRL.cpu_run      <= (next_state == ST_RUN) | runon_live;
			CTRL.periph_run   <= next_state != ST_PDOWN;
			CTRL.osc_run      <= next_state != ST_PDOWN;
			CTRL.ram_write_ok <= ~runon_live & (next_state != ST_PDOWN);
			CTRL.port0_float  <= (next_state != ST_RUN) & EXT_PROG_MEM;
			CTRL.port2_addr   <= (next_state == ST_IDLE) & EXT_PROG_MEM;
			ADDR_LATCH_STROBE    <= next_state == ST_IDLE;
			PROGRAM_STORE_STROBE <= next_state == ST_IDLE;
			CLK_EN       <= ~div2 & (state != ST_PDOWN);
			DEVICE_RESET <= rst_long;
			MODE         <= next_state;
		end
	end
endmodule : ipd_ctrl

/* ipd_ctrl_asserts.sv */
// port checker for the mode controller
// bound to ipd_ctrl from the bench top
`timescale 1ns/100ps
module ipd_ctrl_asserts (
	input wire logic               CLK_SYS,
	input wire logic               SYS_RST,
	input wire logic               RST_PIN,
	input wire logic               IRQ_ENABLED,
	input wire logic               AVS_READ,
	input wire logic               AVS_WRITE,
	input wire logic               AVS_WAITREQUEST,
	input wire logic               CLK_EN,
	input wire ipd_pkg::ipd_ctrl_t CTRL,
	input wire logic               ADDR_LATCH_STROBE,
	input wire logic               PROGRAM_STORE_STROBE,
	input wire logic               DEVICE_RESET,
	input wire logic [1:0]         MODE
);
	import ipd_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	wire idl = MODE == 2'h1;
	wire pdn = MODE == 2'h2;
	idle_strobe_a: assert property (idl |-> ADDR_LATCH_STROBE && PROGRAM_STORE_STROBE)
		else $error("strobes low in idle");
	pdown_strobe_a: assert property (pdn |-> !ADDR_LATCH_STROBE && !PROGRAM_STORE_STROBE)
		else $error("strobes high in power-down");
	pdown_osc_a: assert property (pdn |-> !CTRL.osc_run && !CTRL.cpu_run)
		else $error("oscillator or cpu running in power-down");
	clk_div_a: assert property ((!pdn && !DEVICE_RESET)[*3] |-> CLK_EN != $past(CLK_EN))
		else $error("clock enable not halving");
	pdown_hold_a: assert property (pdn && !RST_PIN |=> pdn)
		else $error("power-down left without reset");
	idle_wake_a: assert property (idl && IRQ_ENABLED && !RST_PIN |-> ##[1:3] !idl)
		else $error("interrupt did not end idle");
	runon_a: assert property (idl && $rose(RST_PIN) |-> ##[1:2] (CTRL.cpu_run && !CTRL.ram_write_ok))
		else $error("run-on window wrong");
	bus_ans_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
		else $error("bus not answered");
	cover property (idl ##1 !idl);
	cover property (pdn && IRQ_ENABLED);
	cover property (idl && RST_PIN);
endmodule : ipd_ctrl_asserts

/* ipd_cpu_model.sv */
// cpu-side partner: instruction-done pulses and an interrupt source
// runs on the system clock and reset
`timescale 1ns/100ps
module ipd_cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_req,
	output logic     instr_done,
	output logic     irq_enabled
);
	logic [1:0] cnt;
	always_ff @(posedge clk) begin
		cnt <= rst ? 2'h0 : cnt + 2'h1;
		instr_done <= !rst && cnt == 2'h3; // completion only, no port write after idle entry
		irq_enabled <= !rst && irq_req;
	end
endmodule : ipd_cpu_model

/* idle_powerdown_mode_control_test.sv */
// self-checking bench for the mode controller
// cpu side from ipd_cpu_model, bus and reset pin from here
`timescale 1ns/100ps
module idle_powerdown_mode_control_test;
	import ipd_pkg::*;
	logic clk, rst, pin, irq, ext, rd, wr, done, irqe, wreq, cen, als, pss, dres;
	logic [7:0]  adr;
	logic [31:0] wd, rdat, q;
	logic [1:0]  mode;
	ipd_ctrl_t   c;
	int          bad_count, compares, cyc;
	ipd_ctrl u_dut (.CLK_SYS(clk), .SYS_RST(rst), .RST_PIN(pin), .INSTR_DONE(done),
		.IRQ_ENABLED(irqe), .EXT_PROG_MEM(ext), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
		.CLK_EN(cen), .CTRL(c), .ADDR_LATCH_STROBE(als), .PROGRAM_STORE_STROBE(pss),
		.DEVICE_RESET(dres), .MODE(mode));
	ipd_cpu_model u_cpu (.clk(clk), .rst(rst), .irq_req(irq), .instr_done(done), .irq_enabled(irqe));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task give_verdict;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			give_verdict;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask : bus
	task waitm(input logic [1:0] m);
		for (int i = 0; i < 60 && mode !== m; i++) @(posedge clk);
	endtask : waitm
	task rst_pulse;
		pin <= 1; // held well past two machine cycles and oscillator restart
		repeat (20) @(posedge clk);
		chk(dres, 1);
		pin <= 0;
		irq <= 0;
		repeat (4) @(posedge clk);
		chk(mode, 0);
		bus(0, ADDR_POWER_CONTROL, 0);
		chk(q, 0);
	endtask : rst_pulse
	task t_regs;
		bus(0, ADDR_POWER_CONTROL, 0);
		chk(q, {24'h0, POWER_CONTROL_RST});
		bus(1, 8'h20, 32'hff);
		bus(0, 8'h20, 0);
		chk(q, 0);
		bus(1, ADDR_POWER_CONTROL, 32'h70);
		bus(0, ADDR_POWER_CONTROL, 0);
		chk(q, 0);
	endtask : t_regs
	task t_idle;
		ext <= 1;
		bus(1, ADDR_POWER_CONTROL, 1);
		waitm(1);
		chk({als, pss, c.cpu_run, c.periph_run, c.port0_float, c.port2_addr}, 6'h37);
		bus(0, ADDR_POWER_CONTROL, 0);
		chk(q, 1);
		bus(0, ADDR_STATUS, 0);
		chk(q, 1);
		irq <= 1;
		waitm(0);
		chk(mode, 0);
		irq <= 0;
	endtask : t_idle
	task t_idle_rst;
		ext <= 0;
		bus(1, ADDR_POWER_CONTROL, 1);
		waitm(1);
		pin <= 1;
		repeat (4) @(posedge clk);
		chk({c.cpu_run, c.ram_write_ok}, 2'h2);
		rst_pulse;
	endtask : t_idle_rst
	task t_pdown;
		ext <= 1;
		bus(1, ADDR_POWER_CONTROL, 2);
		waitm(2);
		chk({als, pss, c.osc_run, c.cpu_run, c.port0_float, c.port2_addr}, 6'h02);
		irq <= 1;
		repeat (10) @(posedge clk);
		chk(mode, 2);
		rst_pulse;
	endtask : t_pdown
	initial begin
		{rst, pin, irq, ext, rd, wr, adr, wd} = {1'b1, 45'h0};
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_regs;
		t_idle;
		t_idle_rst;
		t_pdown;
		give_verdict;
	end
endmodule : idle_powerdown_mode_control_test
bind ipd_ctrl ipd_ctrl_asserts u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .RST_PIN(RST_PIN),
	.IRQ_ENABLED(IRQ_ENABLED), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .CTRL(CTRL),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .CLK_EN(CLK_EN), .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE),
	.PROGRAM_STORE_STROBE(PROGRAM_STORE_STROBE), .DEVICE_RESET(DEVICE_RESET), .MODE(MODE));
